// file: etmr_pkg.sv
// Package for the 8-bit timer with two compare channels.
// Assumes an 8-bit register port with byte addresses on the system clock.
package etmr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ETMR_T3_CNT_OFS   = 8'h00_CA;
  localparam logic [7:0] ETMR_T3_CTL_OFS   = 8'h00_CB;
  localparam logic [7:0] ETMR_T3_C0CTL_OFS = 8'h00_CC;
  localparam logic [7:0] ETMR_T3_C0VAL_OFS = 8'h00_CD;
  localparam logic [7:0] ETMR_T3_C1CTL_OFS = 8'h00_CE;
  localparam logic [7:0] ETMR_T3_C1VAL_OFS = 8'h00_CF;
  localparam logic [7:0] ETMR_T4_CNT_OFS   = 8'h00_EA;
  localparam logic [7:0] ETMR_FLAG_OFS     = 8'h00_D8;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] ETMR_CTL_RST  = 8'h00_08;
  localparam logic [7:0] ETMR_CCTL_RST = 8'h00_40;
  localparam logic [7:0] ETMR_VAL_RST  = 8'h00_00;
  localparam int ETMR_CLR_BIT  = 2;
  localparam int ETMR_FLG_OVF  = 0;
  localparam int ETMR_FLG_CH0  = 1;
  localparam int ETMR_FLG_CH1  = 2;
  localparam logic [7:0] ETMR_CNT_TOP  = 8'h00_FF;
  localparam logic [7:0] ETMR_CNT_ZERO = 8'h00_00;

  // ----------------------------------------
  // Modes and actions
  // ----------------------------------------
  localparam logic [1:0] ETMR_MODE_FREE = 2'h0;
  localparam logic [1:0] ETMR_MODE_DOWN = 2'h1;
  localparam logic [1:0] ETMR_MODE_MOD  = 2'h2;
  localparam logic [1:0] ETMR_MODE_UPDN = 2'h3;
  localparam logic [2:0] ETMR_ACT_SET   = 3'h0;
  localparam logic [2:0] ETMR_ACT_CLR   = 3'h1;
  localparam logic [2:0] ETMR_ACT_TGL   = 3'h2;
  localparam logic [2:0] ETMR_ACT_UPSET = 3'h3;
  localparam logic [2:0] ETMR_ACT_UPCLR = 3'h4;
  localparam logic [2:0] ETMR_ACT_SETB  = 3'h5;
  localparam logic [2:0] ETMR_ACT_CLRB  = 3'h6;

  typedef enum logic [1:0] {
    ETMR_DIR_UP   = 2'b01,
    ETMR_DIR_DOWN = 2'b10
  } etmr_dir_e;

  typedef struct packed {
    logic [2:0] div;
    logic       run;
    logic       ovf_mask;
    logic       clr;
    logic [1:0] mode;
  } etmr_ctl_s;

  typedef struct packed {
    logic       unused;
    logic       irq_mask;
    logic [2:0] action;
    logic       enable;
    logic [1:0] resv;
  } etmr_cctl_s;

endpackage : etmr_pkg

// file: etmr_timer.sv
// 8-bit timer/counter with two output-compare channels, flags and DMA triggers.
// Assumes a one-cycle tick enable and a register port sampled on clk.
`timescale 1ns/1ns

module etmr_timer
  import etmr_pkg::*;
#(
  parameter logic [7:0] CNT_ADDR = ETMR_T3_CNT_OFS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       sfr_we,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic      [1:0] cmp_out,
  output logic      [1:0] dma_trig,
  output logic            irq
);

  etmr_ctl_s             ctl;
  etmr_cctl_s [1:0]      cctl;
  logic       [7:0]      cnt;
  logic       [7:0]      cc0_pend;
  logic       [7:0]      cc0_act;
  logic       [7:0]      cc1;
  logic       [6:0]      pre;
  etmr_dir_e             dir;
  logic                  last_up;
  logic                  stepped;
  logic                  tc_evt;
  logic       [2:0]      flags;
  logic       [7:0]      next_cnt;
  etmr_dir_e             next_dir;
  logic                  next_tc;
  logic       [6:0]      div_mask;
  logic                  step;
  logic                  wr_ctl;
  logic                  wr_c0ctl;
  logic                  wr_c0val;
  logic                  wr_c1ctl;
  logic                  wr_c1val;
  logic                  wr_flag;
  logic                  clr_cmd;
  logic                  start_down;
  logic       [1:0]      cmp_hit;
  logic       [1:0]      bnd_set;
  logic       [1:0]      bnd_clr;
  logic       [2:0]      set_evt;
  logic       [2:0]      msk;
  logic       [2:0]      msk_rise;
  logic       [2:0]      req;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    wr_ctl   = sfr_we && (sfr_addr == CNT_ADDR + 8'h00_01);
    wr_c0ctl = sfr_we && (sfr_addr == CNT_ADDR + 8'h00_02);
    wr_c0val = sfr_we && (sfr_addr == CNT_ADDR + 8'h00_03);
    wr_c1ctl = sfr_we && (sfr_addr == CNT_ADDR + 8'h00_04);
    wr_c1val = sfr_we && (sfr_addr == CNT_ADDR + 8'h00_05);
    wr_flag  = sfr_we && (sfr_addr == ETMR_FLAG_OFS);
    clr_cmd  = wr_ctl && sfr_wdata[ETMR_CLR_BIT];
    start_down = wr_ctl && sfr_wdata[4] && !ctl.run
                 && (sfr_wdata[1:0] == ETMR_MODE_DOWN);
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= etmr_ctl_s'(ETMR_CTL_RST);
    end else if (wr_ctl) begin
      ctl     <= etmr_ctl_s'(sfr_wdata);
      ctl.clr <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cctl <= {2{etmr_cctl_s'(ETMR_CCTL_RST)}};
    end else begin
      if (wr_c0ctl) begin
        cctl[0]        <= etmr_cctl_s'(sfr_wdata);
        cctl[0].unused <= 1'b0;
      end
      if (wr_c1ctl) begin
        cctl[1]        <= etmr_cctl_s'(sfr_wdata);
        cctl[1].unused <= 1'b0;
      end
    end
  end

  // Channel 0 value waits for zero, channel 1 is direct
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cc0_pend <= ETMR_VAL_RST;
      cc0_act  <= ETMR_VAL_RST;
      cc1      <= ETMR_VAL_RST;
    end else begin
      if (wr_c0val) begin
        cc0_pend <= sfr_wdata;
      end
      if (cnt == ETMR_CNT_ZERO) begin
        cc0_act <= cc0_pend;
      end
      if (wr_c1val) begin
        cc1 <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  always_comb begin
    div_mask = 7'((8'h00_01 << ctl.div) - 8'h00_01);
    step     = tick && ctl.run && ((pre & div_mask) == div_mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr_cmd) begin
      pre <= 7'h00;
    end else if (tick && ctl.run) begin
      pre <= pre + 7'h01;
    end
  end

  // ----------------------------------------
  // Counter sequencing
  // ----------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    next_tc  = 1'b0;
    case (ctl.mode)
      ETMR_MODE_FREE: begin
        next_cnt = cnt + 8'h00_01;
        next_tc  = (cnt == ETMR_CNT_TOP);
      end
      ETMR_MODE_DOWN: begin
        if (cnt != ETMR_CNT_ZERO) begin
          next_cnt = cnt - 8'h00_01;
          next_tc  = (cnt == 8'h00_01);
        end
      end
      ETMR_MODE_MOD: begin
        if (cnt >= cc0_act) begin
          next_cnt = ETMR_CNT_ZERO;
          next_tc  = 1'b1;
        end else begin
          next_cnt = cnt + 8'h00_01;
        end
      end
      default: begin
        if (dir == ETMR_DIR_UP) begin
          if (cnt >= cc0_act) begin
            next_dir = ETMR_DIR_DOWN;
            if (cnt != ETMR_CNT_ZERO) begin
              next_cnt = cnt - 8'h00_01;
              next_tc  = (cnt == 8'h00_01);
            end
          end else begin
            next_cnt = cnt + 8'h00_01;
          end
        end else if (cnt == ETMR_CNT_ZERO) begin
          next_dir = ETMR_DIR_UP;
        end else begin
          next_cnt = cnt - 8'h00_01;
          next_tc  = (cnt == 8'h00_01);
          if (cnt == 8'h00_01) begin
            next_dir = ETMR_DIR_UP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr_cmd) begin
      cnt     <= ETMR_CNT_ZERO;
      dir     <= ETMR_DIR_UP;
      last_up <= 1'b1;
    end else if (start_down) begin
      cnt <= cc0_act;
    end else if (step) begin
      cnt     <= next_cnt;
      dir     <= next_dir;
      last_up <= next_cnt > cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr_cmd) begin
      stepped <= 1'b0;
      tc_evt  <= 1'b0;
    end else begin
      // A stopped down count is no counting step, so no repeat events at zero
      stepped <= step && !start_down
                 && !((ctl.mode == ETMR_MODE_DOWN) && (cnt == ETMR_CNT_ZERO));
      tc_evt  <= step && !start_down && next_tc;
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  always_comb begin
    cmp_hit[0] = stepped && cctl[0].enable && (cnt == cc0_act);
    cmp_hit[1] = stepped && cctl[1].enable && (cnt == cc1);
    bnd_clr[0] = stepped && (cnt == ETMR_CNT_TOP);
    bnd_set[0] = stepped && (cnt == ETMR_CNT_ZERO);
    bnd_clr[1] = stepped && (cnt == cc0_act);
    bnd_set[1] = bnd_clr[1];
  end

  for (genvar n = 0; n < 2; n++) begin : g_chan
    logic zero_hit;
    logic updn;
    assign zero_hit = stepped && (cnt == ETMR_CNT_ZERO);
    assign updn     = (ctl.mode == ETMR_MODE_UPDN);
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cmp_out[n] <= 1'b0;
      end else if (cctl[n].enable) begin
        case (cctl[n].action)
          ETMR_ACT_SET: begin
            if (cmp_hit[n]) cmp_out[n] <= 1'b1;
          end
          ETMR_ACT_CLR: begin
            if (cmp_hit[n]) cmp_out[n] <= 1'b0;
          end
          ETMR_ACT_TGL: begin
            if (cmp_hit[n]) cmp_out[n] <= !cmp_out[n];
          end
          ETMR_ACT_UPSET: begin
            if (cmp_hit[n] && (last_up || !updn)) cmp_out[n] <= 1'b1;
            else if (cmp_hit[n] || zero_hit) cmp_out[n] <= 1'b0;
          end
          ETMR_ACT_UPCLR: begin
            if (cmp_hit[n] && (last_up || !updn)) cmp_out[n] <= 1'b0;
            else if (cmp_hit[n] || zero_hit) cmp_out[n] <= 1'b1;
          end
          ETMR_ACT_SETB: begin
            if (cmp_hit[n]) cmp_out[n] <= 1'b1;
            else if (bnd_clr[n]) cmp_out[n] <= 1'b0;
          end
          ETMR_ACT_CLRB: begin
            if (cmp_hit[n]) cmp_out[n] <= 1'b0;
            else if (bnd_set[n]) cmp_out[n] <= 1'b1;
          end
          default: begin
            cmp_out[n] <= cmp_out[n];
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_trig <= 2'h0;
    end else begin
      dma_trig <= cmp_hit;
    end
  end

  // ----------------------------------------
  // Flags and interrupt request
  // ----------------------------------------
  always_comb begin
    set_evt  = {cmp_hit[1], cmp_hit[0], tc_evt};
    msk      = {cctl[1].irq_mask, cctl[0].irq_mask, ctl.ovf_mask};
    msk_rise = {wr_c1ctl && sfr_wdata[6] && !cctl[1].irq_mask,
                wr_c0ctl && sfr_wdata[6] && !cctl[0].irq_mask,
                wr_ctl && sfr_wdata[3] && !ctl.ovf_mask};
    req      = (msk & set_evt & ~flags) | (msk_rise & flags);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= 3'h0;
    end else begin
      // Set wins over a simultaneous clear
      flags <= set_evt | (flags & ~({3{wr_flag}} & ~sfr_wdata[2:0]));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |req;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00_00;
    end else if (sfr_addr == CNT_ADDR) begin
      sfr_rdata <= cnt;
    end else if (sfr_addr == CNT_ADDR + 8'h00_01) begin
      sfr_rdata <= {ctl.div, ctl.run, ctl.ovf_mask, 1'b0, ctl.mode};
    end else if (sfr_addr == CNT_ADDR + 8'h00_02) begin
      sfr_rdata <= cctl[0];
    end else if (sfr_addr == CNT_ADDR + 8'h00_03) begin
      sfr_rdata <= cc0_pend;
    end else if (sfr_addr == CNT_ADDR + 8'h00_04) begin
      sfr_rdata <= cctl[1];
    end else if (sfr_addr == CNT_ADDR + 8'h00_05) begin
      sfr_rdata <= cc1;
    end else if (sfr_addr == ETMR_FLAG_OFS) begin
      sfr_rdata <= {5'h00, flags};
    end else begin
      sfr_rdata <= 8'h00_00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cc0_defer;
    (cnt != ETMR_CNT_ZERO) && !clr_cmd |=> $stable(cc0_act);
  endproperty
  a_cc0_defer: assert property (p_cc0_defer) else $error("cc0 changed off zero");

  property p_cc1_now;
    wr_c1val |=> cc1 == $past(sfr_wdata);
  endproperty
  a_cc1_now: assert property (p_cc1_now) else $error("cc1 not direct");

  property p_flag_set;
    cmp_hit[0] |=> flags[ETMR_FLG_CH0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("ch0 flag missed");

  property p_mask_gate;
    irq |-> $past(|(msk | msk_rise));
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("unmasked irq");

  property p_no_repeat;
    flags[ETMR_FLG_CH1] && cmp_hit[1] && !msk_rise[2] && !cmp_hit[0]
      && !tc_evt && !(|msk_rise[1:0]) |=> !irq;
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("repeat request");

  property p_mask_rise;
    msk_rise[0] && flags[ETMR_FLG_OVF] |=> irq;
  endproperty
  a_mask_rise: assert property (p_mask_rise) else $error("mask rise no irq");

  property p_dma;
    cmp_hit[1] |=> dma_trig[1] ##1 (!dma_trig[1] || $past(cmp_hit[1]));
  endproperty
  a_dma: assert property (p_dma) else $error("dma pulse wrong");

  property p_hold;
    !ctl.run && !clr_cmd && !start_down |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved halted");

  property p_clear;
    clr_cmd |=> cnt == ETMR_CNT_ZERO && dir == ETMR_DIR_UP && !ctl.clr;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_free_wrap;
    step && ctl.mode == ETMR_MODE_FREE && cnt == ETMR_CNT_TOP && !clr_cmd && !start_down
      |=> cnt == ETMR_CNT_ZERO ##1 flags[ETMR_FLG_OVF];
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("wrap wrong");

  property p_div1;
    ctl.div == 3'h0 && ctl.run && tick |-> step;
  endproperty
  a_div1: assert property (p_div1) else $error("div1 no step");

  property p_down_quiet;
    ctl.mode == ETMR_MODE_DOWN && cnt == ETMR_CNT_ZERO && !start_down |=> !stepped;
  endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("down count stepped at zero");

  c_updn: cover property (ctl.mode == ETMR_MODE_UPDN && dir == ETMR_DIR_DOWN && tc_evt);
  c_cmp_both: cover property (cmp_hit[0] ##[1:300] cmp_hit[1]);
  c_irq: cover property (irq);
  c_down_done: cover property (ctl.mode == ETMR_MODE_DOWN && tc_evt);

endmodule : etmr_timer

// file: etmr_timer_tb.sv
// Self-checking bench for the 8-bit timer with two compare channels.
// Assumes etmr_pkg and etmr_timer are compiled first; tick is driven here.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end

module etmr_timer_tb
  import etmr_pkg::*;
  ;
  logic       clk;
  logic       rst_n;
  logic       tick;
  logic       sfr_we;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [1:0] cmp_out;
  logic [1:0] dma_trig;
  logic       irq;
  int         fail_count;
  int         total_checks;
  int         seed;
  int         cyc;
  int         n_irq;
  int         n_dma1;
  localparam int LIMIT = 40000;
  // Channel, action, pin after compare, quiet check, flipped check
  localparam int ACT_TAB [8][5] = '{'{0, 5, 1, 115, 140}, '{0, 6, 0, 115, 140},
    '{0, 3, 1, 115, 140}, '{0, 4, 0, 115, 140}, '{1, 3, 1, 115, 140},
    '{1, 4, 0, 115, 140}, '{1, 5, 1, 55, 75}, '{1, 6, 0, 55, 75}};
  localparam int SEQ_ACT [4] = '{1, 0, 2, 2};
  localparam int SEQ_EXP [4] = '{0, 1, 0, 1};

  etmr_timer dut_u (.clk(clk), .rst_n(rst_n), .tick(tick), .sfr_we(sfr_we),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_out(cmp_out), .dma_trig(dma_trig), .irq(irq));

  always #25 clk = ~clk;

  // ----------------------------------------
  // Pulse counting and hang limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (dma_trig[1] === 1'b1) n_dma1 <= n_dma1 + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic logic [7:0] cctl(logic mask, logic [2:0] act, logic en);
    etmr_cctl_s c;
    c = '0;
    c.irq_mask = mask;
    c.action = act;
    c.enable = en;
    return c;
  endfunction : cctl

  function automatic int period(logic [1:0] md, logic [7:0] m);
    if (md == ETMR_MODE_MOD) return int'(m) + 1;
    if (md == ETMR_MODE_UPDN) return 2 * int'(m);
    return 256;
  endfunction : period

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_we    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = sfr_rdata;
  endtask : rd

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask : chk_rd

  task automatic wait_pulse(input int ch, output int t);
    t = -1;
    for (int i = 0; i < 700 && t < 0; i++) begin
      @(posedge clk);
      #1 if (dma_trig[ch] === 1'b1) t = cyc;
    end
    `CHK("dma_pulse_seen", 1'b1, t >= 0)
  endtask : wait_pulse

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v, a, b, m;
    logic [1:0] md;
    int t0, t1, t2, k, ch, ones, s, s1;
    seed = 29;
    fail_count = 0;
    total_checks = 0;
    cyc = 0;
    n_irq = 0;
    n_dma1 = 0;
    clk = 0;
    rst_n = 0;
    tick = 0;
    sfr_we = 0;
    sfr_addr = ETMR_T3_CNT_OFS;
    sfr_wdata = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("cnt_rst", ETMR_T3_CNT_OFS, 8'h00_00);
    chk_rd("ctl_rst", ETMR_T3_CTL_OFS, 8'h00_08);
    chk_rd("c0ctl_rst", ETMR_T3_C0CTL_OFS, 8'h00_40);
    chk_rd("c1ctl_rst", ETMR_T3_C1CTL_OFS, 8'h00_40);
    chk_rd("c0val_rst", ETMR_T3_C0VAL_OFS, 8'h00_00);
    chk_rd("c1val_rst", ETMR_T3_C1VAL_OFS, 8'h00_00);
    chk_rd("flag_rst", ETMR_FLAG_OFS, 8'h00_00);
    chk_rd("unmapped", 8'h00_C0, 8'h00_00);
    wr(ETMR_T3_CNT_OFS, 8'($random(seed)) | 8'h00_01);
    chk_rd("cnt_ro", ETMR_T3_CNT_OFS, 8'h00_00);
    wr(ETMR_T3_CTL_OFS, 8'h00_0C);
    chk_rd("clr_reads_0", ETMR_T3_CTL_OFS, 8'h00_08);
    $display("test reset_regs done");
    // Random ticks, divide by one
    wr(ETMR_T3_CTL_OFS, 8'h00_14);
    repeat (3) @(posedge clk);
    rd(ETMR_T3_CNT_OFS, a);
    ones = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      v = 8'($random(seed));
      tick <= v[0];
      ones += v[0];
    end
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ETMR_T3_CNT_OFS, b);
    v = b - a;
    `CHK("tick_count", 8'(ones), v)
    wr(ETMR_T3_CTL_OFS, 8'h00_00);
    tick <= 1'b1;
    rd(ETMR_T3_CNT_OFS, a);
    repeat (20) @(posedge clk);
    rd(ETMR_T3_CNT_OFS, b);
    `CHK("halted", a, b)
    $display("test counting done");
    for (k = 0; k < 8; k++) begin
      wr(ETMR_T3_CTL_OFS, 8'(k << 5) | 8'h00_14);
      repeat (2 << k) @(posedge clk);
      rd(ETMR_T3_CNT_OFS, a);
      repeat ((4 << k) - 3) @(posedge clk);
      rd(ETMR_T3_CNT_OFS, b);
      v = b - a;
      `CHK("prescale", 8'h00_04, v)
    end
    $display("test prescaler done");
    // Deferred channel 0 value against immediate channel 1 value
    wr(ETMR_T3_CTL_OFS, 8'h00_00);
    wr(ETMR_T3_C0VAL_OFS, 8'h00_40);
    wr(ETMR_T3_C1VAL_OFS, 8'h00_40);
    wr(ETMR_T3_C0CTL_OFS, cctl(1'b0, ETMR_ACT_SET, 1'b1));
    wr(ETMR_T3_C1CTL_OFS, cctl(1'b0, ETMR_ACT_SET, 1'b1));
    wr(ETMR_T3_CTL_OFS, 8'h00_14);
    repeat (4) @(posedge clk);
    wr(ETMR_T3_C0VAL_OFS, 8'h00_80);
    wr(ETMR_T3_C1VAL_OFS, 8'h00_80);
    wait_pulse(0, t0);
    wait_pulse(1, t1);
    wait_pulse(0, t2);
    `CHK("ch1_now", 64, t1 - t0)
    `CHK("ch0_defer", 320, t2 - t0)
    $display("test compare_update done");
    for (k = 0; k < 4; k++) begin
      wr(ETMR_T3_C1CTL_OFS, cctl(1'b0, 3'(SEQ_ACT[k]), 1'b1));
      wait_pulse(1, t0);
      repeat (3) @(posedge clk);
      #1 `CHK("pin_basic", 1'(SEQ_EXP[k]), cmp_out[1])
    end
    for (k = 0; k < 8; k++) begin
      if (k == 4) begin
        wr(ETMR_T3_C0CTL_OFS, 8'h00_00);
        wr(ETMR_T3_C0VAL_OFS, 8'h00_C0);
        repeat (300) @(posedge clk);
      end
      ch = ACT_TAB[k][0];
      wr(ETMR_T3_C0CTL_OFS + 8'(2 * ch), cctl(1'b0, 3'(ACT_TAB[k][1]), 1'b1));
      wait_pulse(ch, t0);
      wait_pulse(ch, t0);
      repeat (3) @(posedge clk);
      #1 `CHK("pin_on_cmp", 1'(ACT_TAB[k][2]), cmp_out[ch])
      repeat (ACT_TAB[k][3] - 3) @(posedge clk);
      #1 `CHK("pin_held", 1'(ACT_TAB[k][2]), cmp_out[ch])
      repeat (ACT_TAB[k][4] - ACT_TAB[k][3]) @(posedge clk);
      #1 `CHK("pin_second", !1'(ACT_TAB[k][2]), cmp_out[ch])
    end
    wr(ETMR_T3_C1CTL_OFS, cctl(1'b0, ETMR_ACT_TGL, 1'b0));
    s = n_dma1;
    repeat (600) @(posedge clk);
    `CHK("disabled_dma", 0, n_dma1 - s)
    $display("test output_actions done");
    // Flags and requests
    v = 8'($random(seed));
    m = 8'h00_10 + {1'b0, v[6:0]};
    wr(ETMR_T3_C1VAL_OFS, m);
    wr(ETMR_FLAG_OFS, 8'h00_00);
    wr(ETMR_T3_C1CTL_OFS, cctl(1'b1, ETMR_ACT_SET, 1'b1));
    s = n_irq;
    s1 = n_dma1;
    repeat (512) @(posedge clk);
    `CHK("irq_once", 1, n_irq - s)
    `CHK("dma_count", 2, n_dma1 - s1)
    chk_rd("flags_set", ETMR_FLAG_OFS, 8'h00_05);
    wr(ETMR_T3_C1CTL_OFS, cctl(1'b0, ETMR_ACT_SET, 1'b1));
    wr(ETMR_FLAG_OFS, 8'h00_00);
    s = n_irq;
    repeat (300) @(posedge clk);
    `CHK("masked_irq", 0, n_irq - s)
    chk_rd("flags_again", ETMR_FLAG_OFS, 8'h00_05);
    s = n_irq;
    wr(ETMR_T3_C1CTL_OFS, cctl(1'b1, ETMR_ACT_SET, 1'b1));
    repeat (3) @(posedge clk);
    `CHK("mask_set_irq", 1, n_irq - s)
    wr(ETMR_FLAG_OFS, 8'h00_04);
    s = n_irq;
    wr(ETMR_T3_CTL_OFS, 8'h00_18);
    repeat (600) @(posedge clk);
    `CHK("ovf_irq", 1, n_irq - s)
    $display("test flags_irq done");
    // Counting modes
    m = 8'h00_10 + (8'($random(seed)) & 8'h00_3F);
    wr(ETMR_T3_C0CTL_OFS, cctl(1'b0, ETMR_ACT_TGL, 1'b1));
    wr(ETMR_T3_C0VAL_OFS, m);
    for (k = 0; k < 3; k++) begin
      md = (k == 0) ? ETMR_MODE_FREE : 2'(k + 1);
      wr(ETMR_T3_CTL_OFS, {6'h05, md} | 8'h00_10);
      wait_pulse(0, t0);
      wait_pulse(0, t1);
      wait_pulse(0, t2);
      `CHK("mode_period", period(md, m), t2 - t1)
    end
    wr(ETMR_T3_CTL_OFS, 8'h00_05);
    chk_rd("clr_mode_rd", ETMR_T3_CTL_OFS, 8'h00_01);
    wr(ETMR_FLAG_OFS, 8'h00_00);
    wr(ETMR_T3_CTL_OFS, 8'h00_11);
    rd(ETMR_T3_CNT_OFS, v);
    `CHK("down_loaded", 1'b1, v != 8'h00_00 && v <= m)
    repeat (int'(m) + 10) @(posedge clk);
    chk_rd("down_end", ETMR_T3_CNT_OFS, 8'h00_00);
    rd(ETMR_FLAG_OFS, v);
    `CHK("down_ovf", 1'b1, v[ETMR_FLG_OVF])
    $display("test modes done");
    print_verdict();
  end
endmodule : etmr_timer_tb
